/* design/erl_logger.sv */
// error result logger: turns measurement events into time-stamped log entries
// assumes event inputs come from logic on the same clock, so none is synchronised
`timescale 1ns/1ps
module erl_logger (
    input logic clk,
    input logic nrst,
    input erl_pkg::erl_apb_req_t apb_req,
    output erl_pkg::erl_apb_rsp_t apb_rsp,
    input logic [erl_pkg::STAMP_W-1:0] time_of_day,
    input logic gating,
    input logic sec_tick,
    input erl_pkg::erl_meas_t sec_meas,
    input logic gate_end,
    input erl_pkg::erl_meas_t end_meas,
    input logic snapshot_request,
    input erl_pkg::erl_meas_t live_meas,
    input logic user_layout_half,
    input logic [erl_pkg::NALARM-1:0] alarm_active,
    input logic power_fail,
    input logic power_restore,
    output logic entry_valid,
    input logic entry_ready,
    output erl_pkg::erl_entry_t entry,
    output logic [4:0] printer_bus_addr,
    output logic bus_controller_enable
);
    import erl_pkg::*;

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        erl_cfg_t cfg;
        logic [RATIO_W-1:0] thresh;
        erl_entry_t [DEPTH-1:0] mem;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [PTR_W:0] cnt;
        logic ovf_sent;
        logic [31:0] drops;
        logic [NREQ-1:0] req;
        logic [3:0] consec;
        logic squelched;
        logic gating_q;
        logic [NALARM-1:0] alarm_q;
        erl_meas_t sec_m;
        erl_meas_t end_m;
        erl_meas_t snap_m;
        logic [31:0] prdata;
        logic pslverr;
    } erl_state_t;

    erl_state_t s_q;
    erl_state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    // ***************************************************************
    // reset release
    // ***************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ***************************************************************
    // next state
    // ***************************************************************
    erl_cfg_t wcfg;
    erl_entry_t e;
    logic [NREQ-1:0] new_req;
    logic [NREQ-1:0] grant;
    logic [3:0] gidx;
    logic any_req;
    logic flush;
    logic pop;
    logic push;
    logic sec_trig;
    logic end_hit;
    logic log_on;
    logic [NALARM-1:0] alm_rise;
    logic [NALARM-1:0] alm_fall;
    logic [3:0] cause;

    always_comb begin
        s_d = s_q;
        wcfg = s_q.cfg;
        new_req = '0;
        grant = '0;
        gidx = 4'h0;
        flush = 1'b0;
        push = 1'b0;
        cause = 4'h0;
        // R21 off stops new header, second, squelch and end entries
        log_on = s_q.cfg.logging_enable;
        pop = (s_q.cnt != '0) && entry_ready;

        // ---- register bus ----
        if (apb_req.psel && !apb_req.penable) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            unique case (apb_req.paddr)
                ADDR_CTRL: s_d.prdata = 32'(s_q.cfg);
                ADDR_THRESH: s_d.prdata = 32'(s_q.thresh);
                ADDR_STATUS: s_d.prdata = 32'({s_q.gating_q, s_q.squelched,
                                               s_q.ovf_sent, s_q.cnt});
                ADDR_DROPS: s_d.prdata = s_q.drops;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
            if (apb_req.paddr == ADDR_CTRL) begin
                wcfg = erl_cfg_t'(apb_req.pwdata[CTRL_W-1:0]);
                // R2 triggers frozen
                if (s_q.cfg.logging_enable) begin
                    wcfg.ratio_trigger_select = s_q.cfg.ratio_trigger_select;
                    wcfg.end_trig = s_q.cfg.end_trig;
                end
                // unused end trigger code is refused, old choice kept
                if (!(wcfg.end_trig inside {END_ALWAYS, END_NONZERO, END_RATIO})) begin
                    wcfg.end_trig = s_q.cfg.end_trig;
                end
                // R20 flush on enable
                if (wcfg.logging_enable && !s_q.cfg.logging_enable) begin
                    flush = 1'b1;
                end
                s_d.cfg = wcfg;
            end
            // R3 threshold range check
            if (apb_req.paddr == ADDR_THRESH && apb_req.pwdata[31:RATIO_W] == '0
                && apb_req.pwdata[RATIO_W-1:0] <= RATIO_MAX_CODE) begin
                s_d.thresh = apb_req.pwdata[RATIO_W-1:0];
            end
        end

        // ---- gating start ----
        s_d.gating_q = gating;
        // R24 header once at start
        if (gating && !s_q.gating_q && log_on) begin
            new_req[RQ_HEADER] = 1'b1;
        end

        // ---- per-second triggers and squelch ----
        // R1 R23 one trigger selected
        sec_trig = s_q.cfg.ratio_trigger_select ? (sec_meas.ratio < s_q.thresh)
                                                : (sec_meas.count != '0);
        // R14 only gated seconds counted
        if (sec_tick && gating) begin
            s_d.sec_m = sec_meas;
            if (sec_trig) begin
                if (s_q.consec != SQUELCH_SECONDS) begin
                    s_d.consec = s_q.consec + 4'h1;
                end
                // R4 second entry
                if (!s_q.squelched && log_on) begin
                    new_req[RQ_SECOND] = 1'b1;
                end
                // R13 squelch start
                if (s_q.cfg.squelch_enable && !s_q.squelched
                    && s_q.consec + 4'h1 == SQUELCH_SECONDS) begin
                    s_d.squelched = 1'b1;
                    new_req[RQ_SQ_START] = log_on;
                end
            end else begin
                s_d.consec = 4'h0;
                // R16 squelch end message
                if (s_q.squelched) begin
                    s_d.squelched = 1'b0;
                    new_req[RQ_SQ_END] = log_on;
                end
            end
        end
        // R15 squelch survives periods
        // nothing clears it when gating stops

        // ---- end of measurement ----
        // R7 end trigger choice
        unique case (s_q.cfg.end_trig)
            END_NONZERO: end_hit = end_meas.count != '0;
            END_RATIO: end_hit = end_meas.ratio < s_q.thresh;
            default: end_hit = 1'b1;
        endcase
        // R14 end logging ignores squelch
        if (gate_end) begin
            s_d.end_m = end_meas;
            new_req[RQ_END] = end_hit && log_on;
        end

        // ---- snapshot ----
        // R8 R17 snapshot always taken
        if (snapshot_request) begin
            s_d.snap_m = live_meas;
            new_req[RQ_SNAP] = 1'b1;
            // R9 header unless both on
            new_req[RQ_SNAP_HDR] = !(log_on && gating);
        end

        // ---- alarms ----
        s_d.alarm_q = alarm_active;
        alm_rise = alarm_active & ~s_q.alarm_q;
        alm_fall = ~alarm_active & s_q.alarm_q;
        // R10 occurrence and recovery
        if (s_q.cfg.alarm_log_enable) begin
            new_req[RQ_ALM_ON +: NALARM] = alm_rise;
            new_req[RQ_ALM_OFF +: NALARM] = alm_fall;
        end
        // R11 power always logged
        new_req[RQ_PWR_FAIL] = power_fail;
        new_req[RQ_PWR_OK] = power_restore;

        // ---- pick one request per cycle ----
        any_req = |s_q.req;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (s_q.req[i]) begin
                gidx = 4'(i);
            end
        end
        if (any_req) begin
            grant[gidx] = 1'b1;
        end
        // a request raised while its slot is granted survives
        s_d.req = (s_q.req & ~grant) | new_req;

        // ---- build entry ----
        e.kind = K_HEADER;
        e.stamp = time_of_day;
        e.meas = s_q.sec_m;
        e.aux = 8'(s_q.cfg);
        if (gidx >= RQ_ALM_OFF) begin
            cause = gidx - RQ_ALM_OFF;
        end else if (gidx >= RQ_ALM_ON) begin
            cause = gidx - RQ_ALM_ON;
        end
        unique case (gidx)
            RQ_HEADER: e.kind = K_HEADER;
            RQ_SECOND: e.kind = K_SECOND;
            RQ_SQ_START: e.kind = K_SQ_START;
            RQ_SQ_END: e.kind = K_SQ_END;
            RQ_END: begin
                e.meas = s_q.end_m;
                // R5 R6 content and layout
                if (!s_q.cfg.end_content_select) begin
                    e.kind = K_END_FULL;
                end else if (user_layout_half) begin
                    e.kind = K_END_USER_HALF;
                end else begin
                    e.kind = K_END_USER_FULL;
                end
            end
            RQ_SNAP_HDR: e.kind = K_SNAP_HEADER;
            RQ_SNAP: begin
                e.kind = K_SNAP;
                e.meas = s_q.snap_m;
            end
            RQ_PWR_FAIL: e.kind = K_PWR_FAIL;
            RQ_PWR_OK: e.kind = K_PWR_OK;
            default: begin
                e.kind = (gidx >= RQ_ALM_OFF) ? K_ALARM_OFF : K_ALARM_ON;
                e.aux = 8'(1 << cause);
            end
        endcase

        // ---- pending buffer ----
        if (any_req) begin
            if (s_q.cnt < CNT_LAST || (s_q.cnt == CNT_LAST && pop)) begin
                push = 1'b1;
            end else if (s_q.cnt == CNT_LAST && !s_q.ovf_sent) begin
                // R18 last slot holds the overflow note
                e.kind = K_OVERFLOW;
                push = 1'b1;
                s_d.ovf_sent = 1'b1;
                s_d.drops = s_q.drops + 32'h1;
            end else begin
                s_d.drops = s_q.drops + 32'h1;
            end
        end
        // R19 silent recovery
        if (s_q.cnt < CNT_LAST) begin
            s_d.ovf_sent = 1'b0;
        end
        if (push) begin
            s_d.mem[s_q.wr] = e;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

        // R12 power loss drops pending work
        if (power_fail) begin
            flush = 1'b1;
            s_d.req = new_req;
        end
        // flush wins over this cycle's push; a granted request is lost with it
        if (flush) begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
            s_d.ovf_sent = 1'b0;
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign apb_rsp.prdata = s_q.prdata;
    assign apb_rsp.pslverr = s_q.pslverr;
    // zero wait states: every access completes in its first access cycle
    assign apb_rsp.pready = 1'b1;
    assign entry_valid = s_q.cnt != '0;
    assign entry = s_q.mem[s_q.rd];
    // R22 fixed printer address
    assign printer_bus_addr = PRINTER_BUS_ADDR;
    assign bus_controller_enable = s_q.cfg.bus_controller_enable;

endmodule

/* design/erl_pkg.sv */
// constants, carriers and enumerations of the error result logger
// assumes one 50 MHz clock shared with the measurement core that drives it
//
// Notes on behaviour
// R1 - during gating, log on errored second or on second ratio above threshold
// R2 - trigger selections are frozen while logging is enabled
// R3 - threshold and ratio triggers accept only 1.0 down to 1.0E-20
// R4 - each gating trigger logs last second's count and ratio with time stamp
// R5 - end content: full mode logs full results, user mode the user list
// R6 - user mode logs the list of the screen layout in use
// R7 - end logging fires always, on nonzero count, or ratio above threshold
// R8 - snapshot logs current results whatever gating and logging state
// R9 - snapshot prepends header unless logging and gating both on
// R10 - enabled alarms log cause, occurrence and recovery with times
// R11 - power fail and restore always logged with time stamps
// R12 - pending results are lost on power failure
// R13 - squelch after ten consecutive trigger seconds, logging a start message
// R14 - only gating triggers count toward squelch; end logging still output
// R15 - squelch state persists across end of measurement
// R16 - squelch ends after a trigger free second, logging message and results
// R17 - squelch never touches snapshot output
// R18 - full buffer discards results and logs an overflow message once
// R19 - storing resumes silently once space frees up
// R20 - switching logging on flushes the pending buffer
// R21 - switching logging off stops storing but keeps buffered results
// R22 - printer sits at fixed bus address 1
// R23 - errored second is a gated second with nonzero error count
// R24 - header logged once at gating start when logging on, before entries
package erl_pkg;

    // ***************************************************************
    // sizes and timing
    // ***************************************************************
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam logic [PTR_W:0] CNT_FULL = 5'h10;
    localparam logic [PTR_W:0] CNT_LAST = 5'h0f;
    localparam logic [3:0] SQUELCH_SECONDS = 4'ha;
    localparam logic [4:0] PRINTER_BUS_ADDR = 5'h01;
    // ratio code is -100*log10(ratio): 0 is 1.0, 2000 is 1.0E-20
    localparam int RATIO_W = 12;
    localparam logic [RATIO_W-1:0] RATIO_MAX_CODE = 12'h7d0;
    localparam int STAMP_W = 40;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_THRESH = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_DROPS = 8'h0c;
    localparam int CTRL_W = 8;

    typedef enum logic [1:0] {
        END_ALWAYS = 2'h0,
        END_NONZERO = 2'h1,
        END_RATIO = 2'h2
    } erl_end_trig_t;

    // control register layout, bit 0 upward from the bottom field
    typedef struct packed {
        logic bus_controller_enable;
        logic alarm_log_enable;
        logic squelch_enable;
        logic end_content_select;
        erl_end_trig_t end_trig;
        logic ratio_trigger_select;
        logic logging_enable;
    } erl_cfg_t;

    typedef enum logic [3:0] {
        K_HEADER = 4'h0,
        K_SECOND = 4'h1,
        K_END_FULL = 4'h2,
        K_END_USER_FULL = 4'h3,
        K_END_USER_HALF = 4'h4,
        K_SNAP_HEADER = 4'h5,
        K_SNAP = 4'h6,
        K_ALARM_ON = 4'h7,
        K_ALARM_OFF = 4'h8,
        K_PWR_FAIL = 4'h9,
        K_PWR_OK = 4'ha,
        K_SQ_START = 4'hb,
        K_SQ_END = 4'hc,
        K_OVERFLOW = 4'hd
    } erl_kind_t;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic [31:0] count;
        logic [RATIO_W-1:0] ratio;
    } erl_meas_t;

    typedef struct packed {
        erl_kind_t kind;
        logic [STAMP_W-1:0] stamp;
        erl_meas_t meas;
        logic [7:0] aux;
    } erl_entry_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } erl_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } erl_apb_rsp_t;

    // request slots, lower index is logged first
    localparam int NREQ = 15;
    localparam logic [3:0] RQ_HEADER = 4'h0;
    localparam logic [3:0] RQ_SECOND = 4'h1;
    localparam logic [3:0] RQ_SQ_START = 4'h2;
    localparam logic [3:0] RQ_SQ_END = 4'h3;
    localparam logic [3:0] RQ_END = 4'h4;
    localparam logic [3:0] RQ_SNAP_HDR = 4'h5;
    localparam logic [3:0] RQ_SNAP = 4'h6;
    localparam logic [3:0] RQ_PWR_FAIL = 4'h7;
    localparam logic [3:0] RQ_PWR_OK = 4'h8;
    localparam logic [3:0] RQ_ALM_ON = 4'h9;
    localparam logic [3:0] RQ_ALM_OFF = 4'hc;
    localparam int NALARM = 3;

endpackage

/* test/erl_logger_monitor.sv */
// concurrent checks on the ports of the error result logger
// assumes it is bound into every erl_logger instance
`timescale 1ns/1ps
module erl_logger_monitor (
    input wire logic clk,
    input wire logic nrst,
    input erl_pkg::erl_apb_req_t apb_req,
    input erl_pkg::erl_apb_rsp_t apb_rsp,
    input wire logic gating,
    input wire logic gate_end,
    input wire logic snapshot_request,
    input wire logic power_fail,
    input wire logic entry_valid,
    input wire logic entry_ready,
    input erl_pkg::erl_entry_t entry,
    input wire logic [4:0] printer_bus_addr,
    input wire logic bus_controller_enable
);
    import erl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence setup_s;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence access_s;
        apb_req.psel && apb_req.penable;
    endsequence
    // ************************************************
    // assertions
    // ************************************************
    pready_high_a: assert property (access_s |-> apb_rsp.pready)
        else $error("pready low in access phase");
    mapped_ok_a: assert property (setup_s ##0 (apb_req.paddr[7:4] == 4'h0
        && apb_req.paddr[1:0] == 2'h0) ##1 access_s |-> !apb_rsp.pslverr)
        else $error("error on mapped register");
    unmapped_err_a: assert property (setup_s ##0 (apb_req.paddr[7:4] != 4'h0)
        ##1 access_s |-> apb_rsp.pslverr)
        else $error("no error on unmapped address");
    ctrl_write_a: assert property (access_s ##0 (apb_req.pwrite && apb_req.paddr == ADDR_CTRL)
        |=> bus_controller_enable == $past(apb_req.pwdata[7]))
        else $error("controller enable not written");
    bus_addr_a: assert property (printer_bus_addr == PRINTER_BUS_ADDR)
        else $error("printer address not 1");
    entry_hold_a: assert property (entry_valid && !entry_ready && !power_fail
        && !(apb_req.psel && apb_req.penable && apb_req.pwrite)
        |=> entry_valid && $stable(entry))
        else $error("entry changed while waiting");
    snap_header_a: assert property (snapshot_request && !gating && !entry_valid
        && !gate_end && !power_fail |-> ##2 entry_valid && entry.kind == K_SNAP_HEADER)
        else $error("snapshot without header");
    power_fail_a: assert property (power_fail |-> ##2 entry_valid
        && entry.kind == K_PWR_FAIL)
        else $error("power fail not logged first");
endmodule
bind erl_logger erl_logger_monitor u_mon (.clk(clk), .nrst(nrst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .gating(gating), .gate_end(gate_end),
    .snapshot_request(snapshot_request), .power_fail(power_fail), .entry_valid(entry_valid),
    .entry_ready(entry_ready), .entry(entry), .printer_bus_addr(printer_bus_addr),
    .bus_controller_enable(bus_controller_enable));

/* test/erl_printer_model.sv */
// printer model at the far side of the entry stream
// assumes the bench drives stall and slow just after rising edges
`timescale 1ns/1ps
module erl_printer_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic slow,
    input wire logic [4:0] printer_bus_addr,
    output logic entry_ready
);
    import erl_pkg::*;
    logic phase_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    assign entry_ready = !stall && (!slow || phase_q) && printer_bus_addr == PRINTER_BUS_ADDR;
endmodule

/* test/tb_top.sv */
// self-checking bench for the error result logger
// assumes the printer model and the bound port checker
`timescale 1ns/1ps
module tb_top;
    import erl_pkg::*;
    logic clk, nrst, gating, half, stall, slow, bce, entry_valid, entry_ready, err;
    logic [4:0] ev;
    logic [4:0] baddr;
    logic [2:0] alarm;
    logic [STAMP_W-1:0] tod;
    logic [STAMP_W-1:0] t_ev;
    logic [31:0] rd;
    erl_apb_req_t req;
    erl_apb_rsp_t rsp;
    erl_meas_t meas;
    erl_entry_t entry, last;
    erl_entry_t got_q[$];
    int n_errors, samples_checked, i;
    erl_logger DUT (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
        .time_of_day(tod), .gating(gating), .sec_tick(ev[0]), .sec_meas(meas),
        .gate_end(ev[1]), .end_meas(meas), .snapshot_request(ev[2]), .live_meas(meas),
        .user_layout_half(half), .alarm_active(alarm), .power_fail(ev[3]),
        .power_restore(ev[4]), .entry_valid(entry_valid), .entry_ready(entry_ready),
        .entry(entry), .printer_bus_addr(baddr), .bus_controller_enable(bce));
    erl_printer_model u_prn (.clk(clk), .nrst(nrst), .stall(stall), .slow(slow),
        .printer_bus_addr(baddr), .entry_ready(entry_ready));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        tod <= nrst ? tod + 1'b1 : '0;
        if (entry_valid === 1'b1 && entry_ready === 1'b1) begin
            got_q.push_back(entry);
        end
    end
    // ************************************************
    // tasks
    // ************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        req <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (rsp.pready !== 1'b1 && t < 50);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
        chk(t < 50, 1);
    endtask
    // which: 0 second, 1 end, 2 snapshot, 3 power fail, 4 power restore
    task automatic pulse(input int which, input logic [31:0] c, input logic [11:0] r);
        ev <= 5'h01 << which;
        meas <= {c, r};
        @(posedge clk);
        // the entry is written one edge after the event, with the next time value
        t_ev = tod + 1'b1;
        ev <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic expk(input erl_kind_t k);
        int t;
        t = 0;
        while (got_q.size() == 0 && t < 300) begin
            @(posedge clk);
            t++;
        end
        last = got_q.size() > 0 ? got_q.pop_front() : '1;
        chk(last.kind, k);
    endtask
    task automatic none;
        repeat (20) @(posedge clk);
        chk(got_q.size(), 0);
    endtask
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        final_report;
    end
    // ************************************************
    // tests
    // ************************************************
    initial begin
        {nrst, gating, half, stall, slow, ev, alarm, req, meas} = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, ADDR_CTRL, 0);
        chk(rd, 0);
        apb(0, ADDR_THRESH, 0);
        chk(rd, 0);
        apb(1, 8'h10, 32'hff);
        chk(err, 1);
        apb(0, 8'h10, 0);
        chk({err, rd}, 33'h100000000);
        apb(1, ADDR_THRESH, 32'h7d1);
        apb(0, ADDR_THRESH, 0);
        chk(rd, 0);
        apb(1, ADDR_THRESH, RATIO_MAX_CODE);
        apb(0, ADDR_THRESH, 0);
        chk(rd, 32'h7d0);
        apb(1, ADDR_THRESH, 32'hc8);
        apb(1, ADDR_CTRL, 32'h01);
        apb(1, ADDR_CTRL, 32'h07);
        apb(0, ADDR_CTRL, 0);
        chk(rd, 32'h01);
        apb(1, ADDR_CTRL, 32'h00);
        apb(1, ADDR_CTRL, 32'h06);
        apb(0, ADDR_CTRL, 0);
        chk(rd, 32'h06);
        apb(1, ADDR_CTRL, 32'h81);
        chk(bce, 1);
        gating <= 1'b1;
        expk(K_HEADER);
        pulse(0, 0, 12'h000);
        pulse(0, 5, 12'h12c);
        expk(K_SECOND);
        chk(last.meas, {32'h5, 12'h12c});
        chk(last.stamp, t_ev);
        none;
        apb(1, ADDR_CTRL, 32'h80);
        apb(1, ADDR_CTRL, 32'h83);
        pulse(0, 5, 12'h12c);
        pulse(0, 5, 12'h064);
        expk(K_SECOND);
        chk(last.meas.ratio, 12'h064);
        none;
        apb(1, ADDR_CTRL, 32'h80);
        apb(1, ADDR_CTRL, 32'ha1);
        // an error free second clears the run left by the ratio test
        pulse(0, 0, 12'h000);
        for (i = 0; i < 12; i++) pulse(0, 1, 12'h000);
        pulse(1, 0, 12'h000);
        gating <= 1'b0;
        @(posedge clk);
        gating <= 1'b1;
        pulse(0, 3, 12'h000);
        pulse(0, 0, 12'h1ff);
        for (i = 0; i < 10; i++) expk(K_SECOND);
        expk(K_SQ_START);
        expk(K_END_FULL);
        expk(K_HEADER);
        expk(K_SQ_END);
        chk(last.meas, {32'h0, 12'h1ff});
        apb(1, ADDR_CTRL, 32'h80);
        apb(1, ADDR_CTRL, 32'h95);
        pulse(1, 0, 12'h000);
        half <= 1'b1;
        pulse(1, 3, 12'h000);
        expk(K_END_USER_HALF);
        half <= 1'b0;
        pulse(1, 3, 12'h000);
        expk(K_END_USER_FULL);
        apb(1, ADDR_CTRL, 32'h80);
        apb(1, ADDR_CTRL, 32'h89);
        pulse(1, 3, 12'h12c);
        pulse(1, 3, 12'h064);
        expk(K_END_FULL);
        chk(last.meas, {32'h3, 12'h064});
        pulse(2, 7, 12'h000);
        expk(K_SNAP);
        none;
        gating <= 1'b0;
        pulse(2, 7, 12'h000);
        expk(K_SNAP_HEADER);
        expk(K_SNAP);
        chk(last.meas, {32'h7, 12'h000});
        apb(1, ADDR_CTRL, 32'h80);
        alarm <= 3'h2;
        none;
        alarm <= 3'h0;
        apb(1, ADDR_CTRL, 32'hc0);
        for (i = 0; i < 3; i++) begin
            alarm <= 3'h1 << i;
            expk(K_ALARM_ON);
            chk(last.aux, 8'h01 << i);
            alarm <= 3'h0;
            expk(K_ALARM_OFF);
        end
        apb(1, ADDR_CTRL, 32'h80);
        pulse(4, 0, 12'h000);
        expk(K_PWR_OK);
        stall <= 1'b1;
        for (i = 0; i < 20; i++) pulse(4, 0, 12'h000);
        apb(0, ADDR_DROPS, 0);
        chk(rd, 5);
        slow <= 1'b1;
        stall <= 1'b0;
        for (i = 0; i < 15; i++) expk(K_PWR_OK);
        expk(K_OVERFLOW);
        pulse(4, 0, 12'h000);
        expk(K_PWR_OK);
        none;
        stall <= 1'b1;
        pulse(4, 0, 12'h000);
        apb(1, ADDR_CTRL, 32'h01);
        stall <= 1'b0;
        none;
        stall <= 1'b1;
        gating <= 1'b1;
        pulse(0, 2, 12'h000);
        apb(1, ADDR_CTRL, 32'h00);
        pulse(0, 2, 12'h000);
        stall <= 1'b0;
        expk(K_HEADER);
        expk(K_SECOND);
        none;
        stall <= 1'b1;
        pulse(4, 0, 12'h000);
        pulse(3, 0, 12'h000);
        stall <= 1'b0;
        expk(K_PWR_FAIL);
        none;
        final_report;
    end
endmodule
